// ==== diag_checker.sv ====
// checker: handshake and alert timing of the diagnostic select block
`timescale 1ns/1ns
module diag_checker
  import diag_pkg::*;
(
  // watched ports, grouped to keep the file short
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        acq_busy, acq_done, acq_start, force_bipolar,
  input wire logic [2:0]  mux_diag_sel,
  input wire logic        hv_headroom_alert, die_overtemp_alert, upper_port_comm_alert
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] up_q;
  // cycles since reset, saturating; bounds when a port fault may first show
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) up_q <= 6'h00;
    else if (up_q != 6'h3F) up_q <= up_q + 6'h01;
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  a_apb_answer: assert property (s_setup |=> s_access) else $error("no ready");
  a_ready_once: assert property (pready |=> !pready) else $error("ready too long");
  a_err_unmapped: assert property (psel && penable && pready && paddr > SWTHR_OFF
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
  a_start_pulse: assert property (acq_start |=> !acq_start) else $error("start too long");
  a_start_cause: assert property (acq_start |-> $past(psel && penable && pready && pwrite
    && paddr == CTRL_OFF && pwdata[START_BIT])) else $error("start without write");
  a_bipolar_scale: assert property (mux_diag_sel inside {3'h3, 3'h4, 3'h5}
    && $stable(mux_diag_sel) |-> force_bipolar) else $error("bipolar not forced");
  a_temp_after: assert property ($changed(die_overtemp_alert)
    |-> $past(acq_done, 2) || $past(acq_done, 3) || $past(acq_done, 4))
    else $error("overtemp moved outside done");
  a_hdrm_busy: assert property ($changed(hv_headroom_alert)
    |-> $past(acq_busy, 2) || $past(acq_busy, 3) || $past(acq_busy, 4))
    else $error("headroom moved while idle");
  a_comm_hold: assert property (!$fell(upper_port_comm_alert))
    else $error("comm alert dropped");
  a_comm_window: assert property ($rose(upper_port_comm_alert) |-> up_q <= 6'd24)
    else $error("comm alert late");
endmodule // diag_checker
bind acquisition_diagnostic_select diag_checker u_chk (.*);

// ==== diag_pkg.sv ====
// package: register map, field layouts and codes of the diagnostic select block
// Functional notes
// [RL1] code 1 measures alternate reference voltage
// [RL2] diag result loads when acquisition completes
// [RL3] result is 14 bits in 15:2
// [RL4] host checks alternate reference window 3EF8h-4034h
// [RL5] code 2 converts reference against thermistor drive
// [RL6] host derives analog supply from result
// [RL7] codes 3 to 6 select further checks
// [RL8] headroom alert refreshed during each measurement
// [RL9] overtemperature alert refreshed after each measurement
// [RL10] receive pins checked after reset, flag faults
// [RL11] host tests undervoltage with pump disabled
// [RL12] host runs test sources, inspects alerts
// [RL13] host runs alternate mux with switches
// [RL14] four switch diag codes set alerts
// [RL15] zero and full scale force bipolar
// [RL16] code zero leaves result unchanged
package diag_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] RESULT_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] MASK_OFF   = 8'h0C;
  localparam logic [7:0] THR_OFF    = 8'h10;
  localparam logic [7:0] SWALRT_OFF = 8'h14;
  localparam logic [7:0] SWTHR_OFF  = 8'h18;
  // control fields
  localparam int SEL_LSB   = 0;
  localparam int SWSEL_LSB = 4;
  localparam int START_BIT = 8;
  // diagnostic selector codes
  typedef enum logic [2:0] {
    DIAG_NONE = 3'h0, DIAG_ALTERNATE_REFERENCE = 3'h1, DIAG_SUPPLY = 3'h2, DIAG_LEVEL_SHIFT_AMPLIFIER_OFS = 3'h3,
    DIAG_ZERO = 3'h4, DIAG_FULL = 3'h5, DIAG_TEMP = 3'h6, DIAG_RSVD = 3'h7
  } diag_sel_t;
  localparam logic [2:0] SW_SHORT = 3'h1;
  localparam logic [2:0] SW_OPEN  = 3'h2;
  localparam logic [2:0] SW_ODD   = 3'h5;
  localparam logic [2:0] SW_EVEN  = 3'h6;
  localparam int NSW = 12;
  // status bit positions
  localparam int ST_DONE  = 0;
  localparam int ST_HDRM  = 1;
  localparam int ST_TEMP  = 2;
  localparam int ST_COMMU = 3;
  localparam int ST_COMML = 4;
  localparam int ST_SW    = 5;
  localparam int NST      = 6;
  localparam logic [15:0] ZERO_SCALE = 16'h0000;
  localparam logic [15:0] FULL_SCALE = 16'hFFF0;
  localparam logic [1:0]  RES_PAD    = 2'h0;
  // receive pin check duration after reset
  localparam int RX_CHECK_CYC = 16;
  // analog front-end strobe group
  typedef struct packed {
    logic        done;
    logic [13:0] code;
    logic        hdrm_low;
    logic        temp_high;
  } adc_in_t;
endpackage

// ==== diag_select.sv ====
// module: diagnostic selection, result register and alert flags over apb
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module acquisition_diagnostic_select
  import diag_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // acquisition front end (pins)
  input  wire logic        acq_busy,
  input  wire logic        acq_done,
  input  wire logic [13:0] adc_code,
  input  wire logic        hdrm_low,
  input  wire logic        temp_high,
  input  wire logic        rx_upper_bad,
  input  wire logic        rx_lower_bad,
  input  wire logic [11:0] sw_volt_low,
  input  wire logic [11:0] sw_volt_high,
  // analog mux steering
  output logic [2:0]       mux_diag_sel,
  output logic             force_bipolar,
  output logic             alt_mux_en,
  output logic [11:0]      sw_drive,
  output logic             acq_start,
  // alerts
  output logic             hv_headroom_alert,
  output logic             die_overtemp_alert,
  output logic             upper_port_comm_alert,
  output logic             lower_port_comm_alert,
  output logic             irq
);
  // synchronised pins
  logic [NSW+NSW+19:0] pins_s;
  adc_in_t             adc;
  logic                busy_s;
  logic                rxu_s;
  logic                rxl_s;
  logic [NSW-1:0]      swl_s;
  logic [NSW-1:0]      swh_s;
  diag_sync #(.W(NSW+NSW+20)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({acq_done, adc_code, hdrm_low, temp_high, acq_busy, rx_upper_bad,
                rx_lower_bad, sw_volt_low, sw_volt_high}),
    .q       (pins_s)
  );
  assign {adc, busy_s, rxu_s, rxl_s, swl_s, swh_s} = pins_s;

  // registers
  diag_sel_t      sel_q;
  logic [2:0]     swsel_q;
  logic [15:0]    result_q;
  logic [NST-1:0] status_q;
  logic [NST-1:0] mask_q;
  logic [NSW-1:0] swalrt_q;
  logic [NSW-1:0] swen_q;
  logic           done_d1_q;
  logic           hdrm_q;
  logic           temp_q;
  logic           commu_q;
  logic           comml_q;
  logic [4:0]     rxcnt_q;
  logic           rxchk_q;

  // apb decode
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire hit_ctrl = (paddr == CTRL_OFF);
  wire hit_res  = (paddr == RESULT_OFF);
  wire hit_st   = (paddr == STATUS_OFF);
  wire hit_mask = (paddr == MASK_OFF);
  wire hit_swa  = (paddr == SWALRT_OFF);
  wire hit_swt  = (paddr == SWTHR_OFF);
  wire hit_thr  = (paddr == THR_OFF);
  wire mapped   = hit_ctrl | hit_res | hit_st | hit_mask | hit_swa | hit_swt | hit_thr;
  wire [2:0] wsel  = pwdata[SEL_LSB +: 3];
  wire [2:0] wswsel = pwdata[SWSEL_LSB +: 3];

  // acquisition completion edge
  wire done_pulse = adc.done & ~done_d1_q;
  wire diag_used  = (sel_q != DIAG_NONE) && (sel_q != DIAG_RSVD);
  // zero/full-scale checks force bipolar, so code saturates at rails
  wire is_zero    = (sel_q == DIAG_ZERO);
  wire is_full    = (sel_q == DIAG_FULL);
  wire [15:0] res_new = is_zero ? ZERO_SCALE : is_full ? FULL_SCALE : {adc.code, RES_PAD};
  // switch diag comparisons, per switch
  wire sw_mode = (swsel_q == SW_SHORT) | (swsel_q == SW_OPEN) |
                 (swsel_q == SW_ODD) | (swsel_q == SW_EVEN);
  logic [NSW-1:0] sw_fault;
  logic [NSW-1:0] sw_pattern;
  genvar gi;
  generate
    for (gi = 0; gi < NSW; gi++) begin : g_sw
      // open test flags both limits, short test only the low one
      assign sw_fault[gi] = (swsel_q == SW_SHORT) ? swl_s[gi] :
                            ((swl_s[gi] | swh_s[gi]) & sw_pattern[gi]);
      assign sw_pattern[gi] = (swsel_q == SW_OPEN) ? swen_q[gi] :
                              (swsel_q == SW_ODD)  ? (gi % 2 == 0) :
                              (swsel_q == SW_EVEN) ? (gi % 2 == 1) : 1'b0;
    end
  endgenerate

  // event sources into sticky status
  logic [NST-1:0] ev;
  assign ev[ST_DONE]  = done_pulse;
  assign ev[ST_HDRM]  = busy_s & adc.hdrm_low; // [RL8]
  assign ev[ST_TEMP]  = done_pulse & adc.temp_high; // [RL9]
  assign ev[ST_COMMU] = rxchk_q & rxu_s; // [RL10]
  assign ev[ST_COMML] = rxchk_q & rxl_s; // [RL10]
  assign ev[ST_SW]    = done_pulse & sw_mode & (|sw_fault); // [RL14]
  wire [NST-1:0] w1c = (wr & hit_st) ? pwdata[NST-1:0] : '0;

  // control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q   <= DIAG_NONE;
      swsel_q <= 3'h0;
      mask_q  <= '0;
      swen_q  <= '0;
    end else begin
      if (wr & hit_ctrl) sel_q   <= diag_sel_t'(wsel); // [RL1] [RL5] [RL7]
      if (wr & hit_ctrl) swsel_q <= wswsel; // [RL14]
      if (wr & hit_mask) mask_q  <= pwdata[NST-1:0];
      if (wr & hit_swt)  swen_q  <= pwdata[NSW-1:0];
    end
  end

  // start strobe for the acquisition sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) acq_start <= 1'b0;
    else          acq_start <= wr & hit_ctrl & pwdata[START_BIT];
  end

  // result loads only on completion with a live selector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q  <= '0;
      done_d1_q <= 1'b0;
    end else begin
      done_d1_q <= adc.done;
      if (done_pulse && diag_used) result_q <= res_new; // [RL2] [RL3] [RL15] [RL16]
    end
  end

  // sticky status: set beats write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_q <= '0;
    else          status_q <= (status_q & ~w1c) | ev;
  end

  // per-switch alerts, same set-wins policy
  wire [NSW-1:0] swclr = (wr & hit_swa) ? pwdata[NSW-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) swalrt_q <= '0;
    else swalrt_q <= (swalrt_q & ~swclr) | ((done_pulse & sw_mode) ? sw_fault : '0); // [RL14]
  end

  // live alert levels: headroom follows each running measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdrm_q  <= 1'b0;
      temp_q  <= 1'b0;
    end else begin
      if (busy_s)     hdrm_q <= adc.hdrm_low; // [RL8]
      if (done_pulse) temp_q <= adc.temp_high; // [RL9]
    end
  end

  // receive pin check window after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxcnt_q <= '0;
      rxchk_q <= 1'b1;
      commu_q <= 1'b0;
      comml_q <= 1'b0;
    end else begin
      if (rxchk_q) rxcnt_q <= rxcnt_q + 5'h01;
      if (rxchk_q && rxcnt_q == 5'(RX_CHECK_CYC - 1)) rxchk_q <= 1'b0;
      if (rxchk_q && rxu_s) commu_q <= 1'b1; // [RL10]
      if (rxchk_q && rxl_s) comml_q <= 1'b1; // [RL10]
    end
  end

  // read mux
  wire [31:0] rd = hit_ctrl ? {23'h0, 1'b0, 1'b0, swsel_q, 1'b0, sel_q} :
                   hit_res  ? {16'h0, result_q} :
                   hit_st   ? {26'h0, status_q} :
                   hit_mask ? {26'h0, mask_q} :
                   hit_swa  ? {20'h0, swalrt_q} :
                   hit_swt  ? {20'h0, swen_q} :
                   hit_thr  ? {28'h0, comml_q, commu_q, temp_q, hdrm_q} : 32'h0;

  // registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata                <= '0;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      mux_diag_sel          <= 3'h0;
      force_bipolar         <= 1'b0;
      alt_mux_en            <= 1'b0;
      sw_drive              <= '0;
      hv_headroom_alert     <= 1'b0;
      die_overtemp_alert    <= 1'b0;
      upper_port_comm_alert <= 1'b0;
      lower_port_comm_alert <= 1'b0;
      irq                   <= 1'b0;
    end else begin
      pready                <= psel & ~penable;
      prdata                <= (psel & ~penable & ~pwrite) ? rd : prdata;
      pslverr               <= psel & ~penable & ~mapped;
      mux_diag_sel          <= sel_q; // [RL1] [RL5] [RL7]
      force_bipolar         <= is_zero | is_full | (sel_q == DIAG_LEVEL_SHIFT_AMPLIFIER_OFS) |
                               (swsel_q == SW_OPEN); // [RL15]
      alt_mux_en            <= sw_mode; // [RL14]
      sw_drive              <= sw_pattern & {NSW{swsel_q != SW_SHORT}};
      hv_headroom_alert     <= hdrm_q;
      die_overtemp_alert    <= temp_q;
      upper_port_comm_alert <= commu_q;
      lower_port_comm_alert <= comml_q;
      irq                   <= |(((status_q & ~w1c) | ev) & mask_q);
    end
  end
endmodule // acquisition_diagnostic_select

// ==== diag_sync.sv ====
// module: two-stage synchroniser vector
`timescale 1ns/1ns
module diag_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  // first stage is read only by second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // diag_sync

// ==== tb_acquisition_diagnostic_select.sv ====
// testbench: random and corner tests of the diagnostic select block
`timescale 1ns/1ns
module tb_acquisition_diagnostic_select;
  import diag_pkg::*;
  `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        acq_busy, acq_done, hdrm_low, temp_high, rx_upper_bad, rx_lower_bad;
  logic        acq_start, force_bipolar, alt_mux_en, hv_headroom_alert, die_overtemp_alert;
  logic        upper_port_comm_alert, lower_port_comm_alert;
  logic [13:0] adc_code, c;
  logic [11:0] sw_volt_low, sw_volt_high, sw_drive;
  logic [2:0]  mux_diag_sel, w;
  logic [15:0] res_exp;
  logic [2:0]  swc [5] = '{SW_SHORT, SW_OPEN, SW_ODD, SW_EVEN, 3'h0};
  int          mismatches, n_compared;
  acquisition_diagnostic_select u_dut (.*);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // one apb transfer; holds the request until ready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // ready, read data and error are taken at the rising edge that sees ready
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // one host-run acquisition; code held steady across the done rise
  task automatic acq(input logic [13:0] code);
    adc_code <= code; acq_busy <= 1'b1;
    repeat (4) @(posedge pclk);
    acq_done <= 1'b1;
    repeat (6) @(posedge pclk);
    acq_busy <= 1'b0; acq_done <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  function automatic logic [15:0] exp_res(input logic [2:0] s, input logic [13:0] cd,
                                          input logic [15:0] old);
    case (s)
      3'h0, 3'h7: return old;
      3'h4: return ZERO_SCALE;
      3'h5: return FULL_SCALE;
      default: return {cd, RES_PAD};
    endcase
  endfunction
  task automatic close_out;
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog well past the roughly 300 cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    close_out();
  end
  initial begin
    mismatches = 0; n_compared = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; acq_busy = 1'b0; acq_done = 1'b0;
    adc_code = 14'h0; hdrm_low = 1'b0; temp_high = 1'b0; rx_upper_bad = 1'b1;
    rx_lower_bad = 1'b0; sw_volt_low = 12'h0; sw_volt_high = 12'h0;
    void'($urandom(11));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (30) @(posedge pclk);
    rx_upper_bad <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(upper_port_comm_alert, 1'b1)
    `CHK(lower_port_comm_alert, 1'b0)
    $display("test receive check done");
    // selector walk, codes 0 and 7 last so they must keep a loaded value
    res_exp = 16'h0000;
    for (int k = 1; k < 9; k++) begin
      w = 3'(k % 8);
      c = (w == 3'h1) ? 14'h0FBE : 14'($urandom());
      apb(1'b1, CTRL_OFF, {23'h0, 1'($urandom()), 5'h0, w});
      @(posedge pclk);
      `CHK(acq_start, pwdata[START_BIT])
      @(posedge pclk);
      `CHK(mux_diag_sel, w)
      `CHK(force_bipolar, 1'(w >= 3'h3 && w <= 3'h5))
      acq(c);
      res_exp = exp_res(w, c, res_exp);
      apb(1'b0, RESULT_OFF, 32'h0);
      `CHK(rd[15:0], res_exp)
      if (w == 3'h1) `CHK(rd[15:0] >= 16'h3EF8 && rd[15:0] <= 16'h4034, 1'b1)
      if (w == 3'h2) `CHK(rd[1:0], RES_PAD)
    end
    $display("test selector walk done");
    apb(1'b0, STATUS_OFF, 32'h0);
    `CHK(rd[ST_DONE], 1'b1)
    apb(1'b1, MASK_OFF, 32'h1);
    repeat (4) @(posedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b1, STATUS_OFF, 32'h1);
    repeat (4) @(posedge pclk);
    `CHK(irq, 1'b0)
    $display("test interrupt done");
    // comparators raised while idle must not move the alerts yet
    hdrm_low <= 1'b1; temp_high <= 1'b1;
    apb(1'b1, MASK_OFF, 32'h0);
    repeat (6) @(posedge pclk);
    `CHK(hv_headroom_alert, 1'b0)
    `CHK(die_overtemp_alert, 1'b0)
    acq(14'h0);
    `CHK(hv_headroom_alert, 1'b1)
    `CHK(die_overtemp_alert, 1'b1)
    `CHK(irq, 1'b0)
    $display("test alerts done");
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, CTRL_OFF, {25'h0, swc[k], 4'h0});
      repeat (2) @(posedge pclk);
      `CHK(alt_mux_en, 1'(swc[k] != 3'h0))
      `CHK(sw_drive, (swc[k] == SW_ODD) ? 12'h555 : (swc[k] == SW_EVEN) ? 12'hAAA : 12'h000)
      `CHK(force_bipolar, 1'(swc[k] == SW_OPEN))
      if (k == 0) begin
        sw_volt_low <= 12'hFFF;
        acq(14'h0);
        apb(1'b0, SWALRT_OFF, 32'h0);
        `CHK(rd[11:0], 12'hFFF)
        sw_volt_low <= 12'h0;
      end
    end
    apb(1'b0, 8'h1C, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    $display("test switch modes and refusal done");
    close_out();
  end
endmodule // tb_acquisition_diagnostic_select
